// file: common/bss_pkg.sv
// Functional notes
// - Straps 1:0 pick clock: 00 crystal, 01 8 kHz sync, 10 16 kHz, 11 reserved.
// - Strap 2 picks boot source: 0 host boot, 1 automatic flash boot.
// - Straps default to 0 by pull-downs; only a pull-up gives 1.
// - Flash boot turns general-purpose pin 9 into the flash chip select.
// - Boot runs after hardware reset, power-up and firmware swap.
// - Straps are sampled once after each reset, not on a swap boot, and kept readable as boot sense.
// - Flash boot copies image, applies configuration defaults, then starts executing.
// - Host boot and host swap wait for the host to write program memory.
// - Reset pin low over 10 us drives core supply control low.
// - Supply select low: core supply control drives the regulator transistor.
// - After reset: regulator on, then PLL on with strapped source, wait lock.
// - After lock, queue an event and pull the host interrupt low.
// - First host port, SPI or I2C, to start loading becomes boot master.
// - Two host clock toggles switch the host port to SPI, else I2C.
// - Host port takes SPI up to 25 MHz and I2C up to 400 kHz.
// - Flash boot or flash swap completes in under one second.
// - Without a host only the flash image runs; no swap.
// - Strap pins are released to normal use after sensing.
// - Image is firmware plus a configuration record for user registers.
// - Reset low 100 ns to 10 us gives a full digital reset; here host port SPI mode survives it, only rst_in clears it.
// - At power-up straps are sensed, boot begins 3 ms later.
package bss_pkg;
  localparam int CLK_MHZ       = 100;
  localparam int DIG_MIN_NS    = 100;
  localparam int ANALOG_US     = 10;
  localparam int BOOT_DELAY_MS = 3;
  localparam int BOOT_LIMIT_MS = 1000;
  // Least times round up, the limit rounds down
  localparam int DIG_MIN_CYC    = (DIG_MIN_NS * CLK_MHZ + 999) / 1000;
  localparam int ANALOG_CYC     = ANALOG_US * CLK_MHZ + 1;
  localparam int BOOT_DELAY_CYC = BOOT_DELAY_MS * CLK_MHZ * 1000;
  localparam int BOOT_LIMIT_CYC = BOOT_LIMIT_MS * CLK_MHZ * 1000 - 1;
  localparam int LOWCNT_W       = 10;
  localparam int TMR_W          = 27;
  localparam int HPORT_SPI_TOGGLES = 2;
  // Strap field layout and codes
  localparam int STRAP_CLK_LSB  = 0;
  localparam int STRAP_BOOT_BIT = 2;
  localparam logic [2:0] STRAP_RESET = 3'h0;
  localparam logic [1:0] CLK_XTAL  = 2'h0;
  localparam logic [1:0] CLK_FS8K  = 2'h1;
  localparam logic [1:0] CLK_FS16K = 2'h2;
  localparam logic [1:0] CLK_RSVD  = 2'h3;
  // Gray codes along IDLE..RUN
  typedef enum logic [3:0] {
    ST_IDLE   = 4'h0,
    ST_STRAP  = 4'h1,
    ST_SETTLE = 4'h3,
    ST_REG_UP = 4'h2,
    ST_PLL    = 4'h6,
    ST_READY  = 4'h7,
    ST_FLASH  = 4'h5,
    ST_CFG    = 4'h4,
    ST_RUN    = 4'hC,
    ST_HOST   = 4'hD,
    ST_HOLD   = 4'hF
  } bss_state_type;
  function automatic logic bss_clk_reserved(input logic [2:0] s);
    return s[STRAP_CLK_LSB +: 2] == CLK_RSVD;
  endfunction : bss_clk_reserved
  function automatic logic bss_auto_boot(input logic [2:0] s);
    return s[STRAP_BOOT_BIT];
  endfunction : bss_auto_boot
endpackage : bss_pkg

// file: common/bss_hbi_if.sv
`timescale 1ns/1ps
// Host port mode and boot master selection between sequencer and detector
interface bss_hport_if;
  logic host_clk;
  logic spi_start;
  logic i2c_start;
  logic arm;
  logic spi_mode;
  logic master_valid;
  logic master_spi;
  modport det (input host_clk, spi_start, i2c_start, arm,
               output spi_mode, master_valid, master_spi);
  modport seq (output host_clk, spi_start, i2c_start, arm,
               input spi_mode, master_valid, master_spi);
endinterface : bss_hport_if

// file: rtl/bss_hbi_detect.sv
`timescale 1ns/1ps
module bss_hport_detect (
  // Clock and reset
  input  wire logic ref_clk_in,
  input  wire logic rst_in,
  // Host port side
  bss_hport_if.det  hport
);
  import bss_pkg::*;

  logic       clk_prev_q;
  logic [1:0] toggles_q;
  logic       spi_mode_q;
  logic       master_valid_q;
  logic       master_spi_q;

  // Host clock sampled at 4x the fastest SPI clock, so no edge is missed
  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      clk_prev_q <= 1'b0;
      toggles_q  <= 2'h0;
      spi_mode_q <= 1'b0;
    end else begin
      clk_prev_q <= hport.host_clk;
      if (hport.host_clk && !clk_prev_q && !spi_mode_q) begin
        toggles_q <= toggles_q + 2'h1;
        if (toggles_q == 2'(HPORT_SPI_TOGGLES - 1)) begin
          spi_mode_q <= 1'b1;
        end
      end
    end
  end

  // First port to start a transfer while armed keeps mastership
  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      master_valid_q <= 1'b0;
      master_spi_q   <= 1'b0;
    end else if (!hport.arm) begin
      master_valid_q <= 1'b0;
      master_spi_q   <= 1'b0;
    end else if (!master_valid_q && (hport.spi_start || hport.i2c_start)) begin
      master_valid_q <= 1'b1;
      master_spi_q   <= hport.spi_start && spi_mode_q;
    end
  end

  assign hport.spi_mode     = spi_mode_q;
  assign hport.master_valid = master_valid_q;
  assign hport.master_spi   = master_spi_q;
endmodule : bss_hport_detect

// file: rtl/bss_boot_seq.sv
`timescale 1ns/1ps
module bss_boot_seq #(
  parameter int unsigned BOOT_DELAY_CYCLES = bss_pkg::BOOT_DELAY_CYC,
  parameter int unsigned BOOT_LIMIT_CYCLES = bss_pkg::BOOT_LIMIT_CYC
) (
  // Clock and reset
  input  wire logic       ref_clk_in,
  input  wire logic       rst_in,
  // Reset pin and straps
  input  wire logic       hw_reset_n_in,
  input  wire logic [2:0] strap_in,
  // Supply and clocking
  input  wire logic       supply_source_select_in,
  input  wire logic       core_supply_good_in,
  input  wire logic       pll_lock_in,
  // Firmware swap request from host
  input  wire logic       swap_req_in,
  input  wire logic       swap_from_flash_in,
  // Loader status
  input  wire logic       flash_load_done_in,
  input  wire logic       host_load_done_in,
  // Host bus interface activity
  input  wire logic       host_clk_in,
  input  wire logic       spi_xfer_start_in,
  input  wire logic       i2c_xfer_start_in,
  // Supply and PLL control
  output logic            core_supply_control_out,
  output logic            int_reg_drive_out,
  output logic            pll_en_out,
  output logic [1:0]      pll_src_out,
  // Host signalling
  output logic            host_interrupt_n_out,
  output logic            event_push_out,
  // Boot sense and pin use
  output logic [2:0]      boot_sense_out,
  output logic            strap_pins_free_out,
  output logic            gpio9_cs_mode_out,
  output logic            flash_chip_select_n_out,
  // Loader control
  output logic            flash_load_req_out,
  output logic            cfg_apply_out,
  output logic            run_out,
  output logic            boot_timeout_out,
  // Host port mode
  output logic            spi_mode_out,
  output logic            boot_master_valid_out,
  output logic            boot_master_spi_out
);
  import bss_pkg::*;

  // Sequencer state, pin low counter and shared timer
  bss_state_type      state_q;
  bss_state_type      state_d;
  logic [LOWCNT_W-1:0] lowcnt_q;
  logic [TMR_W-1:0]   timer_q;
  // Latched straps and registered copies of the outputs
  logic [2:0]         strap_q;
  logic               core_supply_control_q;
  logic               pll_en_q;
  logic [1:0]         pll_src_q;
  logic               host_interrupt_n_q;
  logic               event_push_q;
  logic               strap_free_q;
  logic               gpio9_cs_q;
  logic               flash_cs_n_q;
  logic               flash_req_q;
  logic               cfg_apply_q;
  logic               run_q;
  logic               timeout_q;
  logic               int_reg_q;
  logic               spi_mode_q;
  logic               master_valid_q;
  logic               master_spi_q;
  // Swap origin and decoded counter conditions
  logic               from_swap_q;
  logic               pin_reset;
  logic               analog_off;
  logic               delay_done;
  logic               limit_hit;

  bss_hport_if hport ();

  // Port mode and master detector
  bss_hport_detect u_detect (
    .ref_clk_in (ref_clk_in),
    .rst_in     (rst_in),
    .hport      (hport.det)
  );

  // Detector is armed only while waiting for a host download
  assign hport.host_clk  = host_clk_in;
  assign hport.spi_start = spi_xfer_start_in;
  assign hport.i2c_start = i2c_xfer_start_in;
  assign hport.arm       = (state_q == ST_HOST);

  // Low time of the reset pin; saturates at the analog threshold
  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      lowcnt_q <= '0;
    end else if (hw_reset_n_in) begin
      lowcnt_q <= '0;
    end else if (lowcnt_q != LOWCNT_W'(ANALOG_CYC)) begin
      lowcnt_q <= lowcnt_q + LOWCNT_W'(1);
    end
  end

  // Shorter glitches are ignored; anything from 100 ns up resets the logic
  assign pin_reset  = (lowcnt_q >= LOWCNT_W'(DIG_MIN_CYC));
  assign analog_off = (lowcnt_q == LOWCNT_W'(ANALOG_CYC));
  assign delay_done = (timer_q == TMR_W'(BOOT_DELAY_CYCLES - 1));
  assign limit_hit  = (timer_q == TMR_W'(BOOT_LIMIT_CYCLES - 1));

  // Next state
  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_IDLE: begin
        // Clock must already be valid when the pin is released
        if (hw_reset_n_in) begin
          state_d = ST_STRAP;
        end
      end
      ST_STRAP: begin
        state_d = ST_SETTLE;
      end
      ST_SETTLE: begin
        if (delay_done) begin
          state_d = ST_REG_UP;
        end
      end
      ST_REG_UP: begin
        if (core_supply_good_in) begin
          state_d = ST_PLL;
        end
      end
      ST_PLL: begin
        if (pll_lock_in) begin
          // Reserved clock code parks the sequencer for good
          state_d = bss_clk_reserved(strap_q) ? ST_HOLD : ST_READY;
        end
      end
      ST_READY: begin
        // A swap lets the host pick the source; otherwise the straps decide
        if (from_swap_q) begin
          state_d = swap_from_flash_in ? ST_FLASH : ST_HOST;
        end else begin
          state_d = bss_auto_boot(strap_q) ? ST_FLASH : ST_HOST;
        end
      end
      ST_FLASH: begin
        // Done wins over the limit when both land in one cycle
        if (flash_load_done_in) begin
          state_d = ST_CFG;
        end else if (limit_hit) begin
          state_d = ST_HOLD;
        end
      end
      ST_CFG: begin
        state_d = ST_RUN;
      end
      ST_HOST: begin
        // Load done means nothing until some port has become master
        if (host_load_done_in && master_valid_q) begin
          state_d = ST_RUN;
        end
      end
      ST_RUN: begin
        // Only a host can ask for a swap, so a hostless system stays put
        if (swap_req_in) begin
          state_d = ST_READY;
        end
      end
      ST_HOLD: begin
        // Only a reset leaves; a timed-out load never retries by itself
        state_d = ST_HOLD;
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
  end

  // State register; a long enough pin pulse restarts from idle
  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      state_q <= ST_IDLE;
    end else if (pin_reset) begin
      state_q <= ST_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // Swap origin, remembered so READY knows who picks the source
  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      from_swap_q <= 1'b0;
    end else if (pin_reset || state_q == ST_IDLE) begin
      from_swap_q <= 1'b0;
    end else if (state_q == ST_RUN && swap_req_in) begin
      from_swap_q <= 1'b1;
    end
  end

  // Shared timer: settle delay, then flash load limit
  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      timer_q <= '0;
    end else if (state_q != state_d || pin_reset) begin
      timer_q <= '0;
    end else if (state_q == ST_SETTLE || state_q == ST_FLASH) begin
      timer_q <= timer_q + TMR_W'(1);
    end
  end

  // Straps caught once after each reset and held; pull-downs make 0 default
  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      strap_q      <= STRAP_RESET;
      strap_free_q <= 1'b0;
    end else if (pin_reset) begin
      strap_q      <= STRAP_RESET;
      strap_free_q <= 1'b0;
    end else if (state_q == ST_STRAP) begin
      strap_q      <= strap_in;
      strap_free_q <= 1'b1;
    end
  end

  // Core supply: off only on a long pin low, kept through short pulses
  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      core_supply_control_q <= 1'b0;
      int_reg_q             <= 1'b0;
    end else if (analog_off) begin
      core_supply_control_q <= 1'b0;
      int_reg_q             <= 1'b0;
    end else if (state_q == ST_REG_UP) begin
      core_supply_control_q <= 1'b1;
      int_reg_q             <= !supply_source_select_in;
    end
  end

  // PLL follows the supply and takes its source from the clock straps
  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      pll_en_q  <= 1'b0;
      pll_src_q <= CLK_XTAL;
    end else if (pin_reset) begin
      pll_en_q  <= 1'b0;
      pll_src_q <= CLK_XTAL;
    end else if (state_q == ST_PLL) begin
      pll_en_q  <= 1'b1;
      pll_src_q <= strap_q[STRAP_CLK_LSB +: 2];
    end
  end

  // Event pulse and interrupt on entry to READY, never from HOLD
  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      event_push_q       <= 1'b0;
      host_interrupt_n_q <= 1'b1;
    end else if (pin_reset) begin
      event_push_q       <= 1'b0;
      host_interrupt_n_q <= 1'b1;
    end else begin
      event_push_q <= (state_d == ST_READY && state_q != ST_READY);
      // Interrupt stays low until the image runs, so a late host still sees it
      if (state_d == ST_READY && state_q != ST_READY) begin
        host_interrupt_n_q <= 1'b0;
      end else if (state_q == ST_RUN) begin
        host_interrupt_n_q <= 1'b1;
      end
    end
  end

  // Pin 9 becomes flash select only in flash boot or flash swap; select active in FLASH
  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      gpio9_cs_q   <= 1'b0;
      flash_cs_n_q <= 1'b1;
      flash_req_q  <= 1'b0;
    end else if (pin_reset) begin
      gpio9_cs_q   <= 1'b0;
      flash_cs_n_q <= 1'b1;
      flash_req_q  <= 1'b0;
    end else begin
      // Pin 9 goes back to general use as soon as the load ends
      gpio9_cs_q   <= (state_d == ST_FLASH);
      flash_cs_n_q <= !(state_d == ST_FLASH);
      flash_req_q  <= (state_d == ST_FLASH);
    end
  end

  // Config defaults applied only after a flash load; host sets its own
  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      cfg_apply_q <= 1'b0;
      run_q       <= 1'b0;
    end else if (pin_reset) begin
      cfg_apply_q <= 1'b0;
      run_q       <= 1'b0;
    end else begin
      cfg_apply_q <= (state_d == ST_CFG);
      run_q       <= (state_d == ST_RUN);
    end
  end

  // Load over the limit is flagged and parks the sequencer
  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      timeout_q <= 1'b0;
    end else if (pin_reset) begin
      timeout_q <= 1'b0;
    end else if (state_q == ST_FLASH && limit_hit && !flash_load_done_in) begin
      timeout_q <= 1'b1;
    end
  end

  // Host port status registered for the outputs
  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      spi_mode_q     <= 1'b0;
      master_valid_q <= 1'b0;
      master_spi_q   <= 1'b0;
    end else begin
      spi_mode_q     <= hport.spi_mode;
      master_valid_q <= hport.master_valid;
      master_spi_q   <= hport.master_spi;
    end
  end

  // Outputs straight from flip-flops
  assign core_supply_control_out = core_supply_control_q;
  assign int_reg_drive_out       = int_reg_q;
  assign pll_en_out              = pll_en_q;
  assign pll_src_out             = pll_src_q;
  assign host_interrupt_n_out    = host_interrupt_n_q;
  assign event_push_out          = event_push_q;
  assign boot_sense_out          = strap_q;
  assign strap_pins_free_out     = strap_free_q;
  assign gpio9_cs_mode_out       = gpio9_cs_q;
  assign flash_chip_select_n_out = flash_cs_n_q;
  assign flash_load_req_out      = flash_req_q;
  assign cfg_apply_out           = cfg_apply_q;
  assign run_out                 = run_q;
  assign boot_timeout_out        = timeout_q;
  assign spi_mode_out            = spi_mode_q;
  assign boot_master_valid_out   = master_valid_q;
  assign boot_master_spi_out     = master_spi_q;
endmodule : bss_boot_seq

// file: tb/bss_boot_monitor.sv
`timescale 1ns/1ps
module bss_boot_monitor (
  // Clock and reset
  input wire logic       ref_clk_in,
  input wire logic       rst_in,
  // Watched inputs
  input wire logic       hw_reset_n_in,
  input wire logic       pll_lock_in,
  input wire logic       flash_load_done_in,
  input wire logic       host_load_done_in,
  // Watched outputs
  input wire logic       core_supply_control_out,
  input wire logic       pll_en_out,
  input wire logic [1:0] pll_src_out,
  input wire logic       host_interrupt_n_out,
  input wire logic       event_push_out,
  input wire logic [2:0] boot_sense_out,
  input wire logic       strap_pins_free_out,
  input wire logic       gpio9_cs_mode_out,
  input wire logic       flash_chip_select_n_out,
  input wire logic       flash_load_req_out,
  input wire logic       cfg_apply_out,
  input wire logic       run_out,
  input wire logic       spi_mode_out
);
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (rst_in);
  // Low run length of the pin, saturating so it never wraps
  logic [10:0] low_cnt_q;
  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      low_cnt_q <= 11'h000;
    end else if (hw_reset_n_in) begin
      low_cnt_q <= 11'h000;
    end else if (low_cnt_q != 11'h7FF) begin
      low_cnt_q <= low_cnt_q + 11'h001;
    end
  end
  a_event_irq_low: assert property (event_push_out |-> !host_interrupt_n_out)
    else $error("event without host interrupt");
  a_event_after_lock: assert property (event_push_out |-> $past(pll_lock_in))
    else $error("event before lock");
  a_reserved_quiet: assert property (strap_pins_free_out && boot_sense_out[1:0] == 2'h3
    |-> host_interrupt_n_out && !event_push_out) else $error("reserved code booted");
  a_cs_flash_load: assert property (!flash_chip_select_n_out
    |-> gpio9_cs_mode_out && flash_load_req_out) else $error("chip select outside load");
  a_pll_src_strap: assert property (pll_en_out |-> pll_src_out == boot_sense_out[1:0])
    else $error("pll source not strapped");
  a_sense_hold: assert property (strap_pins_free_out && $past(strap_pins_free_out)
    |-> $stable(boot_sense_out)) else $error("boot sense changed");
  a_flash_cfg_run: assert property (flash_load_req_out && flash_load_done_in
    |=> cfg_apply_out ##1 run_out) else $error("flash load not applied");
  a_run_cause: assert property ($rose(run_out)
    |-> $past(cfg_apply_out) || $past(host_load_done_in)) else $error("run without load");
  a_spi_sticky: assert property (spi_mode_out |=> spi_mode_out)
    else $error("spi mode dropped");
  a_supply_off: assert property (low_cnt_q >= 11'h3EB |-> !core_supply_control_out)
    else $error("supply on in long reset");
endmodule : bss_boot_monitor

bind bss_boot_seq bss_boot_monitor u_mon (.ref_clk_in, .rst_in, .hw_reset_n_in, .pll_lock_in,
  .flash_load_done_in, .host_load_done_in, .core_supply_control_out, .pll_en_out,
  .pll_src_out, .host_interrupt_n_out, .event_push_out, .boot_sense_out,
  .strap_pins_free_out, .gpio9_cs_mode_out, .flash_chip_select_n_out,
  .flash_load_req_out, .cfg_apply_out, .run_out, .spi_mode_out);

// file: tb/bss_far_model.sv
`timescale 1ns/1ps
module bss_far_model #(
  parameter int RAIL_CYC = 4,
  parameter int LOCK_CYC = 6,
  parameter int LOAD_CYC = 30
) (
  // Clock
  input  wire logic ref_clk_in,
  // Requests from the sequencer, plus the stall from the test
  input  wire logic core_supply_control_in,
  input  wire logic pll_en_in,
  input  wire logic flash_load_req_in,
  input  wire logic stall_in,
  // Answers
  output logic      core_supply_good_out,
  output logic      pll_lock_out,
  output logic      flash_load_done_out
);
  int unsigned rail_q = 0;
  int unsigned lock_q = 0;
  int unsigned load_q = 0;
  // Rail, lock and copy take time; losing the cause drops them at once
  always @(negedge ref_clk_in) begin
    rail_q = core_supply_control_in ? rail_q + 1 : 0;
    lock_q = (pll_en_in && core_supply_good_out) ? lock_q + 1 : 0;
    load_q = (flash_load_req_in && !stall_in) ? load_q + 1 : 0;
  end
  // A stalled flash never finishes, so timeouts can be provoked
  assign core_supply_good_out = rail_q > RAIL_CYC;
  assign pll_lock_out         = lock_q > LOCK_CYC;
  assign flash_load_done_out  = load_q > LOAD_CYC;
endmodule : bss_far_model

// file: tb/tb_bss_boot_seq.sv
`timescale 1ns/1ps
module tb_bss_boot_seq;
  import bss_pkg::*;
  localparam int DLY = 20;
  localparam int LIM = 200;
  // Stimulus
  logic       ref_clk_in = 1'b0, rst_in = 1'b1, hw_reset_n_in = 1'b1;
  logic [2:0] strap_in = 3'h4;
  logic       supply_source_select_in = 1'b0, swap_from_flash_in = 1'b0;
  logic       host_clk_in = 1'b0, stall = 1'b0;
  logic [3:0] act = 4'h0;
  logic       swap_req_in, i2c_xfer_start_in, spi_xfer_start_in, host_load_done_in;
  logic       core_supply_good_in, pll_lock_in, flash_load_done_in;
  // Observed
  logic       core_supply_control_out, int_reg_drive_out, pll_en_out, host_interrupt_n_out;
  logic       event_push_out, strap_pins_free_out, gpio9_cs_mode_out, flash_chip_select_n_out;
  logic       flash_load_req_out, cfg_apply_out, run_out, boot_timeout_out, spi_mode_out;
  logic       boot_master_valid_out, boot_master_spi_out;
  logic [1:0] pll_src_out;
  logic [2:0] boot_sense_out;
  logic [7:0] ev_cnt = 8'h00, cfg_cnt = 8'h00, cs_cnt = 8'h00;
  int         err_total = 0, n_tests = 0;
  wire  [3:0] obs = {boot_timeout_out, ~host_interrupt_n_out, run_out, spi_mode_out};
  assign {swap_req_in, i2c_xfer_start_in, spi_xfer_start_in, host_load_done_in} = act;

  initial begin
    forever #5 ref_clk_in = ~ref_clk_in;
  end

  bss_boot_seq #(.BOOT_DELAY_CYCLES(DLY), .BOOT_LIMIT_CYCLES(LIM)) dut (.ref_clk_in,
    .rst_in, .hw_reset_n_in, .strap_in, .supply_source_select_in, .core_supply_good_in,
    .pll_lock_in, .swap_req_in, .swap_from_flash_in, .flash_load_done_in,
    .host_load_done_in, .host_clk_in, .spi_xfer_start_in, .i2c_xfer_start_in,
    .core_supply_control_out, .int_reg_drive_out, .pll_en_out, .pll_src_out,
    .host_interrupt_n_out, .event_push_out, .boot_sense_out, .strap_pins_free_out,
    .gpio9_cs_mode_out, .flash_chip_select_n_out, .flash_load_req_out, .cfg_apply_out,
    .run_out, .boot_timeout_out, .spi_mode_out, .boot_master_valid_out,
    .boot_master_spi_out);

  bss_far_model u_far (.ref_clk_in(ref_clk_in), .core_supply_control_in(core_supply_control_out),
    .pll_en_in(pll_en_out), .flash_load_req_in(flash_load_req_out), .stall_in(stall),
    .core_supply_good_out(core_supply_good_in), .pll_lock_out(pll_lock_in),
    .flash_load_done_out(flash_load_done_in));

  // One-cycle pulses and chip-select cycles are counted at every rising edge; any reset starts them over
  always @(posedge ref_clk_in) begin
    if (rst_in || !hw_reset_n_in) begin
      ev_cnt <= 8'h00;
      cfg_cnt <= 8'h00;
      cs_cnt <= 8'h00;
    end else begin
      ev_cnt <= ev_cnt + event_push_out;
      cfg_cnt <= cfg_cnt + cfg_apply_out;
      cs_cnt <= cs_cnt + (gpio9_cs_mode_out & ~flash_chip_select_n_out);
    end
  end

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      err_total++;
      $display("unexpected at %0t: got %h want %h", $time, seen, exp);
    end
  endtask : check

  task automatic pin_reset(input logic [2:0] s, input int n);
    @(negedge ref_clk_in);
    strap_in = s;
    hw_reset_n_in = 1'b0;
    repeat (n) @(negedge ref_clk_in);
    hw_reset_n_in = 1'b1;
  endtask : pin_reset

  task automatic wait_bit(input int b, input int lim);
    for (int i = 0; i < lim && obs[b] !== 1'b1; i++) @(negedge ref_clk_in);
    check(8'(obs[b]), 8'h01);
  endtask : wait_bit

  // Host requests last one cycle, then the sequencer gets time to react
  task automatic pulse(input logic [3:0] a);
    act = a;
    @(negedge ref_clk_in);
    act = 4'h0;
    repeat (3) @(negedge ref_clk_in);
  endtask : pulse

  task automatic toggle(input int n);
    repeat (n) begin
      host_clk_in = 1'b1;
      repeat (2) @(negedge ref_clk_in);
      host_clk_in = 1'b0;
      repeat (2) @(negedge ref_clk_in);
    end
  endtask : toggle

  task automatic done(input string s);
    $display("test %s finished", s);
  endtask : done

  task automatic summarize;
    $display("comparisons %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : summarize

  // Whole run is a few thousand cycles; this cuts a hang
  initial begin
    repeat (20000) @(posedge ref_clk_in);
    err_total++;
    summarize();
  end

  initial begin
    repeat (16) @(negedge ref_clk_in);
    rst_in = 1'b0;
    for (int c = 0; c < 3; c++) begin
      pin_reset({1'b1, c[1:0]}, 12);
      repeat (DLY) @(negedge ref_clk_in);
      check(8'(obs[2]), 8'h00);
      wait_bit(2, 60);
      check(8'(boot_sense_out), 8'(4 + c));
      check(8'(pll_src_out), 8'(c));
      check(8'(pll_en_out), 8'h01);
      check(8'(strap_pins_free_out), 8'h01);
      strap_in = ~strap_in;
      wait_bit(1, LIM);
      check(8'(boot_sense_out), 8'(4 + c));
      check(ev_cnt, 8'h01);
      check(cfg_cnt, 8'h01);
      check(8'(cs_cnt != 0), 8'h01);
    end
    done("flash");
    pin_reset(3'h0, 12);
    wait_bit(2, DLY + 60);
    toggle(2);
    repeat (4) @(negedge ref_clk_in);
    check(8'(spi_mode_out), 8'h01);
    pulse(4'h2);
    pulse(4'h4);
    check({boot_master_valid_out, boot_master_spi_out}, 8'h03);
    pulse(4'h1);
    check(8'(run_out), 8'h01);
    check(8'(host_interrupt_n_out), 8'h01);
    check(cs_cnt + cfg_cnt, 8'h00);
    done("spi host");
    rst_in = 1'b1;
    strap_in = 3'h0;
    repeat (2) @(negedge ref_clk_in);
    rst_in = 1'b0;
    wait_bit(2, DLY + 60);
    toggle(1);
    repeat (4) @(negedge ref_clk_in);
    check(8'(spi_mode_out), 8'h00);
    pulse(4'h4);
    pulse(4'h2);
    check({boot_master_valid_out, boot_master_spi_out}, 8'h02);
    pulse(4'h1);
    check(8'(run_out), 8'h01);
    done("i2c host");
    strap_in = 3'h7;
    swap_from_flash_in = 1'b1;
    pulse(4'h8);
    check(8'(flash_chip_select_n_out), 8'h00);
    check(8'(flash_load_req_out), 8'h01);
    wait_bit(1, LIM);
    check(ev_cnt, 8'h02);
    check(8'(boot_sense_out), 8'h00);
    swap_from_flash_in = 1'b0;
    pulse(4'h8);
    pulse(4'h4);
    check({run_out, flash_chip_select_n_out}, 8'h01);
    pulse(4'h1);
    check(8'(run_out), 8'h01);
    done("swap");
    check({core_supply_control_out, int_reg_drive_out}, 8'h03);
    pin_reset(3'h4, 5);
    check(8'(run_out), 8'h01);
    supply_source_select_in = 1'b1;
    pin_reset(3'h4, 1010);
    check({core_supply_control_out, run_out}, 8'h00);
    wait_bit(1, LIM + DLY);
    check({core_supply_control_out, int_reg_drive_out}, 8'h02);
    supply_source_select_in = 1'b0;
    pin_reset(3'h4, 12);
    check(8'(run_out), 8'h00);
    done("reset");
    pin_reset(3'h3, 12);
    repeat (DLY + 80) @(negedge ref_clk_in);
    check({ev_cnt[0], host_interrupt_n_out}, 8'h01);
    stall = 1'b1;
    pin_reset(3'h4, 12);
    wait_bit(3, DLY + LIM + 80);
    check(8'(run_out), 8'h00);
    done("refusals");
    summarize();
  end
endmodule : tb_bss_boot_seq
